// ===== design/pll_lock_supervisor.v
// Clock lock supervisor of a daisy-chained audio bus node
//
// Contract
// - Main node locks to the host frame sync input.
// - Subordinate node locks to the downstream control frame preamble.
// - Each attempt is judged complete or failed within 360 frames.
// - Without lock inside the 7.5 ms window, retry automatically until locked.
// - Missing sync or corrupted preamble counts as a failed attempt, never lock.
// - Subordinate supports local frame rates as multiples or divisors of bus rate.
// - Subordinate locked clock drives bus data recovery and onward transmission.
// - Bus bit rate generated from the locked clock is 49.152 Mbps.
// - Serial port transmit and receive share one bit clock and frame sync.
// - Frame counting uses superframes of 1024 bus clock cycles.
`timescale 1ns/1ns
`default_nettype none
`include "lock_supervisor_defs.vh"

module pll_lock_supervisor
#(
    parameter [19:0] LOCK_WINDOW_CYC = `LOCK_WINDOW_CYC,
    parameter [11:0] REF_MISS_CYC = `REF_MISS_CYC
)
(
    // Clock and reset
    input wire CORE_CLK,
    input wire RESET,
    // Role and reference inputs
    input wire MAIN_MODE,
    input wire SYNC_IN,
    input wire PREAMBLE_OK,
    input wire PREAMBLE_BAD,
    input wire PLL_LOCK_IN,
    // Local frame rate selection
    input wire LOCAL_RATE_DIVIDE,
    input wire [3:0] LOCAL_RATE_FACTOR,
    // PLL control
    output reg PLL_REF_SEL,
    output reg [`SUPERFRAME_W-1:0] PLL_FB_DIV,
    output reg PLL_RESET,
    // Status to host
    output reg LOCKED,
    output reg LOCK_FAIL,
    output reg ATTEMPT_START,
    output reg [7:0] ATTEMPT_COUNT,
    output reg [8:0] FRAME_COUNT,
    // Clock users
    output reg RX_RECOVERY_EN,
    output reg TX_TIMING_EN,
    output wire LOCAL_SYNC
);

////////////////////////////////////////////////////////////////////////////////
// Helpers

function [7:0] sat_inc8;
    input [7:0] v;
    begin
        sat_inc8 = (v == 8'hFF) ? v : v + 8'h01;
    end
endfunction

function [11:0] sat_inc12;
    input [11:0] v;
    begin
        sat_inc12 = (v == 12'hFFF) ? v : v + 12'h001;
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Reference selection

reg sync_prev_r;
reg mode_prev_r;
reg [1:0] state_r;
reg [1:0] state_nxt;
reg [19:0] win_r;
reg [11:0] gap_r;
reg [3:0] rst_cnt_r;
reg [8:0] frames_r;

// Sync edge marks one frame; inputs are already in the core clock domain
always @(posedge CORE_CLK)
begin
    if (RESET)
    begin
        sync_prev_r <= 1'b0;
        mode_prev_r <= 1'b0;
    end
    else
    begin
        sync_prev_r <= SYNC_IN;
        mode_prev_r <= MAIN_MODE;
    end
end

wire sync_rise = SYNC_IN && !sync_prev_r;
wire sub_bad = !MAIN_MODE && PREAMBLE_BAD;
// A corrupted preamble never counts as a frame, even with a good flag beside it
wire ref_tick = MAIN_MODE ? sync_rise : (PREAMBLE_OK && !PREAMBLE_BAD);
wire mode_change = (MAIN_MODE != mode_prev_r);
wire ref_missing = (gap_r >= REF_MISS_CYC);
wire win_expired = (win_r >= LOCK_WINDOW_CYC - 20'h00001);
wire frames_done = (frames_r >= `LOCK_MAX_FRAMES);

////////////////////////////////////////////////////////////////////////////////
// Attempt state machine

always @*
begin
    state_nxt = state_r;
    case (state_r)
        `ST_RESTART:
        begin
            if (rst_cnt_r >= `PLL_RST_CYCLES - 4'h1)
                state_nxt = `ST_ACQUIRE;
        end
        `ST_ACQUIRE:
        begin
            if (mode_change)
                state_nxt = `ST_RESTART;
            else if (sub_bad || ref_missing || win_expired || frames_done)
                state_nxt = `ST_RESTART;
            else if (ref_tick && PLL_LOCK_IN)
                state_nxt = `ST_LOCKED;
        end
        `ST_LOCKED:
        begin
            // Relies on a reference frame (host sync edge or preamble) in every superframe to keep the gap timer short
            if (mode_change || !PLL_LOCK_IN || sub_bad || ref_missing)
                state_nxt = `ST_RESTART;
        end
        default:
        begin
            state_nxt = `ST_RESTART;
        end
    endcase
end

wire acq_fail = (state_r == `ST_ACQUIRE) && (state_nxt == `ST_RESTART) && !mode_change;
wire acq_start = (state_r == `ST_RESTART) && (state_nxt == `ST_ACQUIRE);

always @(posedge CORE_CLK)
begin
    if (RESET)
        state_r <= `ST_RESTART;
    else
        state_r <= state_nxt;
end

////////////////////////////////////////////////////////////////////////////////
// Attempt timers and frame counter

// Window and frame count restart with each attempt so every retry gets full time
always @(posedge CORE_CLK)
begin
    if (RESET || state_r == `ST_RESTART)
    begin
        win_r <= 20'h00000;
        frames_r <= 9'h000;
        rst_cnt_r <= (RESET || state_nxt != `ST_RESTART) ? 4'h0 : rst_cnt_r + 4'h1;
    end
    else
    begin
        rst_cnt_r <= 4'h0;
        if (state_r == `ST_ACQUIRE)
        begin
            win_r <= win_r + 20'h00001;
            if (ref_tick)
                frames_r <= frames_r + 9'h001;
        end
    end
end

// Gap timer detects a reference that has gone quiet
always @(posedge CORE_CLK)
begin
    if (RESET || state_r == `ST_RESTART || ref_tick)
        gap_r <= 12'h000;
    else
        gap_r <= sat_inc12(gap_r);
end

////////////////////////////////////////////////////////////////////////////////
// PLL control and status outputs

always @(posedge CORE_CLK)
begin
    if (RESET)
    begin
        PLL_REF_SEL <= 1'b0;
        PLL_FB_DIV <= `SUPERFRAME_CYCLES;
        PLL_RESET <= 1'b1;
        LOCKED <= 1'b0;
        LOCK_FAIL <= 1'b0;
        ATTEMPT_START <= 1'b0;
        ATTEMPT_COUNT <= 8'h00;
        FRAME_COUNT <= 9'h000;
        RX_RECOVERY_EN <= 1'b0;
        TX_TIMING_EN <= 1'b0;
    end
    else
    begin
        // Low selects host frame sync, high selects the control frame preamble
        PLL_REF_SEL <= !MAIN_MODE;
        // One superframe per reference frame gives the 49.152 Mbps bus rate at 48 kHz
        PLL_FB_DIV <= `SUPERFRAME_CYCLES;
        PLL_RESET <= (state_nxt == `ST_RESTART);
        LOCKED <= (state_nxt == `ST_LOCKED);
        LOCK_FAIL <= acq_fail;
        ATTEMPT_START <= acq_start;
        FRAME_COUNT <= frames_r;
        // Count lets the host enforce its own timeout; cleared once locked
        if (state_nxt == `ST_LOCKED)
            ATTEMPT_COUNT <= 8'h00;
        else if (acq_start)
            ATTEMPT_COUNT <= sat_inc8(ATTEMPT_COUNT);
        // Only a subordinate recovers the incoming stream and retimes onward data
        RX_RECOVERY_EN <= (state_nxt == `ST_LOCKED) && !MAIN_MODE;
        TX_TIMING_EN <= (state_nxt == `ST_LOCKED) && !MAIN_MODE;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Local serial port frame sync

// One pulse train feeds both serial directions so they cannot drift apart
local_frame_gen u_local_frame_gen
(
    .clk(CORE_CLK),
    .rst(RESET),
    .ref_tick(ref_tick),
    .enable(LOCKED),
    .divide(LOCAL_RATE_DIVIDE),
    .factor(LOCAL_RATE_FACTOR),
    .local_sync_r(LOCAL_SYNC)
);

endmodule
`default_nettype wire

// ===== design/lock_supervisor_defs.vh
// Constants for the bus node clock lock supervisor
`ifndef LOCK_SUPERVISOR_DEFS_VH
`define LOCK_SUPERVISOR_DEFS_VH

// Core clock
`define CORE_CLK_HZ 10000000
`define CORE_CLK_PERIOD_NS 100

// Bus timing
`define BUS_BIT_RATE_BPS 49152000
`define SUPERFRAME_CYCLES 11'h400
`define SUPERFRAME_W 11

// Lock attempt bounds
`define LOCK_MAX_FRAMES 9'h168
`define LOCK_WINDOW_NS 7500000
// 7.5 ms counted in 100 ns core cycles, sized to the window counter
`define LOCK_WINDOW_CYC 20'h124F8

// Longest gap between reference frames before the reference counts as missing
`define REF_MISS_NS 50000
// 50 us counted in 100 ns core cycles, sized to the gap timer
`define REF_MISS_CYC 12'h1F4

// Cycles the PLL is held in reset between attempts
`define PLL_RST_CYCLES 4'h4

// Supervisor states
`define ST_RESTART 2'h0
`define ST_ACQUIRE 2'h1
`define ST_LOCKED 2'h2

`endif

// ===== design/local_frame_gen.v
// Local frame sync generator for multiples and divisors of the bus frame rate
`timescale 1ns/1ns
`default_nettype none
`include "lock_supervisor_defs.vh"

module local_frame_gen
(
    // Clock and reset
    input wire clk,
    input wire rst,
    // Reference
    input wire ref_tick,
    input wire enable,
    // Rate selection
    input wire divide,
    input wire [3:0] factor,
    // Shared serial port frame sync
    output reg local_sync_r
);

reg [11:0] period_r;
reg [11:0] gap_r;
reg [15:0] acc_r;
reg [3:0] slot_r;
wire [3:0] fac = (factor == 4'h0) ? 4'h1 : factor;
wire [15:0] acc_sum = acc_r + {12'h000, fac};

////////////////////////////////////////////////////////////////////////////////
// Multiply spreads factor pulses per frame by accumulating; divide skips frames
always @(posedge clk)
begin
    if (rst || !enable)
    begin
        period_r <= 12'hFFF;
        gap_r <= 12'h000;
        acc_r <= 16'h0000;
        slot_r <= 4'h0;
        local_sync_r <= 1'b0;
    end
    else if (ref_tick)
    begin
        period_r <= gap_r + 12'h001;
        gap_r <= 12'h000;
        acc_r <= 16'h0000;
        if (divide)
        begin
            local_sync_r <= (slot_r == 4'h0);
            slot_r <= (slot_r + 4'h1 >= fac) ? 4'h0 : slot_r + 4'h1;
        end
        else
        begin
            local_sync_r <= 1'b1;
            slot_r <= 4'h1;
        end
    end
    else
    begin
        gap_r <= (gap_r == 12'hFFF) ? gap_r : gap_r + 12'h001;
        local_sync_r <= 1'b0;
        if (!divide)
        begin
            // Extra pulses stop at factor so the next reference is not doubled
            if (acc_sum >= {4'h0, period_r} && slot_r < fac)
            begin
                acc_r <= acc_sum - {4'h0, period_r};
                slot_r <= slot_r + 4'h1;
                local_sync_r <= 1'b1;
            end
            else
            begin
                acc_r <= acc_sum;
            end
        end
    end
end

endmodule
`default_nettype wire

// ===== bench/ref_source.sv
// Host frame sync and upstream preamble source for the lock supervisor
`timescale 1ns/1ns
`default_nettype none
module ref_source
#(
    parameter int PERIOD = 20
)
(
    // Clock and controls
    input wire logic clk,
    input wire logic run,
    input wire logic main,
    input wire logic bad_req,
    input wire logic fast,
    // Reference outputs
    output logic sync = 1'b0,
    output logic pre_ok = 1'b0,
    output logic pre_bad = 1'b0
);
    int cnt = 0;
    ////////////////////////////////////////////////////////////////////////////
    // Scaled frame period stands in for the audio rate so that runs stay short
    always @(negedge clk)
    begin
        // Fast frames let the frame limit run out before the attempt window does
        cnt <= (cnt >= (fast ? 3 : PERIOD - 1)) ? 0 : cnt + 1;
        sync <= run && main && (cnt < (fast ? 2 : PERIOD / 2));
        pre_ok <= run && !main && !bad_req && (cnt == 0);
        pre_bad <= run && !main && bad_req && (cnt == 0); // Corrupted preamble on demand
    end
endmodule
`default_nettype wire

// ===== bench/pll_lock_supervisor_props.sv
// Concurrent checks on the lock supervisor ports
`timescale 1ns/1ns
`default_nettype none
module lock_props
#(
    parameter [19:0] LOCK_WINDOW_CYC = 20'h124F8,
    parameter [11:0] REF_MISS_CYC = 12'h1F4
)
(
    // Clock, reset, inputs
    input wire CORE_CLK,
    input wire RESET,
    input wire MAIN_MODE,
    input wire SYNC_IN,
    input wire PREAMBLE_OK,
    input wire PREAMBLE_BAD,
    input wire PLL_LOCK_IN,
    // Outputs
    input wire PLL_REF_SEL,
    input wire [10:0] PLL_FB_DIV,
    input wire PLL_RESET,
    input wire LOCKED,
    input wire LOCK_FAIL,
    input wire ATTEMPT_START,
    input wire [8:0] FRAME_COUNT,
    input wire RX_RECOVERY_EN,
    input wire TX_TIMING_EN,
    input wire LOCAL_SYNC
);
    logic [20:0] win_r;
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RESET);
    ////////////////////////////////////////////////////////////////////////////
    // Cycles spent in the current attempt, cleared by restart or lock
    always @(posedge CORE_CLK)
        win_r <= (RESET || PLL_RESET || LOCKED) ? 21'h0 : win_r + 21'h1;
    ////////////////////////////////////////////////////////////////////////////
    a_reset_hold: assert property (disable iff (1'b0) RESET |=> PLL_RESET && !LOCKED)
        else $error("reset state wrong");
    a_fb_div: assert property (PLL_FB_DIV == 11'h400)
        else $error("feedback divider wrong");
    a_ref_select: assert property (!$past(RESET) |-> PLL_REF_SEL == !$past(MAIN_MODE))
        else $error("reference select wrong");
    a_lock_cause: assert property ($rose(LOCKED) |-> $past(PLL_LOCK_IN) &&
        ($past(MAIN_MODE) ? $past(SYNC_IN) : $past(PREAMBLE_OK) && !$past(PREAMBLE_BAD)))
        else $error("lock without a reference frame");
    a_window_bound: assert property (win_r <= {1'b0, LOCK_WINDOW_CYC} + 21'h2)
        else $error("attempt outlived its window");
    a_frame_bound: assert property (FRAME_COUNT <= 9'h168)
        else $error("frame count over limit");
    a_fail_retry: assert property (LOCK_FAIL |-> PLL_RESET && !LOCKED ##[3:5] ATTEMPT_START)
        else $error("no retry after failure");
    a_fail_pulse: assert property (LOCK_FAIL |=> !LOCK_FAIL)
        else $error("failure event not a pulse");
    a_users_locked: assert property (RX_RECOVERY_EN == TX_TIMING_EN &&
        (!RX_RECOVERY_EN || LOCKED && PLL_REF_SEL))
        else $error("clock users enabled without lock");
    a_sync_locked: assert property (LOCAL_SYNC |-> LOCKED || $past(LOCKED))
        else $error("local sync without lock");
endmodule
bind pll_lock_supervisor lock_props #(.LOCK_WINDOW_CYC(LOCK_WINDOW_CYC),
    .REF_MISS_CYC(REF_MISS_CYC)) props_u (.CORE_CLK, .RESET, .MAIN_MODE, .SYNC_IN,
    .PREAMBLE_OK, .PREAMBLE_BAD, .PLL_LOCK_IN, .PLL_REF_SEL, .PLL_FB_DIV, .PLL_RESET,
    .LOCKED, .LOCK_FAIL, .ATTEMPT_START, .FRAME_COUNT, .RX_RECOVERY_EN, .TX_TIMING_EN,
    .LOCAL_SYNC);
`default_nettype wire

// ===== bench/tb.sv
// Self-checking bench for the clock lock supervisor
`timescale 1ns/1ns
`default_nettype none
module tb;
    localparam int WIN = 2000;
    localparam int MISS = 50;
    logic CORE_CLK = 1'b0;
    logic RESET = 1'b1;
    logic MAIN_MODE = 1'b1;
    logic PLL_LOCK_IN = 1'b0;
    logic LOCAL_RATE_DIVIDE = 1'b1;
    logic [3:0] LOCAL_RATE_FACTOR = 4'h1;
    logic run = 1'b0;
    logic bad_req = 1'b0;
    logic fast = 1'b0;
    logic SYNC_IN, PREAMBLE_OK, PREAMBLE_BAD, PLL_REF_SEL, PLL_RESET, LOCKED, LOCK_FAIL;
    logic ATTEMPT_START, RX_RECOVERY_EN, TX_TIMING_EN, LOCAL_SYNC;
    logic [10:0] PLL_FB_DIV;
    logic [7:0] ATTEMPT_COUNT;
    logic [8:0] FRAME_COUNT;
    logic [7:0] cnt0;
    int bad_count = 0;
    int n_checks = 0;
    int n;
    int k;
    // Rows: divide, mode, factor, reference select, users enabled, local sync pulses
    logic [10:0] rows [0:2] = '{11'h624, 11'h45A, 11'h247};
    ////////////////////////////////////////////////////////////////////////////
    pll_lock_supervisor #(.LOCK_WINDOW_CYC(WIN), .REF_MISS_CYC(MISS)) dut_u (.CORE_CLK,
        .RESET, .MAIN_MODE, .SYNC_IN, .PREAMBLE_OK, .PREAMBLE_BAD, .PLL_LOCK_IN,
        .LOCAL_RATE_DIVIDE, .LOCAL_RATE_FACTOR, .PLL_REF_SEL, .PLL_FB_DIV, .PLL_RESET,
        .LOCKED, .LOCK_FAIL, .ATTEMPT_START, .ATTEMPT_COUNT, .FRAME_COUNT,
        .RX_RECOVERY_EN, .TX_TIMING_EN, .LOCAL_SYNC);
    ref_source src_u (.clk(CORE_CLK), .run(run), .main(MAIN_MODE), .bad_req(bad_req),
        .fast(fast), .sync(SYNC_IN), .pre_ok(PREAMBLE_OK), .pre_bad(PREAMBLE_BAD));
    always #50 CORE_CLK = ~CORE_CLK;
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [19:0] seen, input logic [19:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Wait for lock (0), failure (1) or attempt start (2); settled at the falling edge
    task automatic wait_for(input int sel, input int lim);
        n = 0;
        do
        begin
            @(negedge CORE_CLK);
            n++;
        end
        while (!(sel == 0 ? LOCKED === 1'b1 : sel == 1 ? LOCK_FAIL === 1'b1 :
            ATTEMPT_START === 1'b1) && n < lim);
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Host timeout bounds the endless retries
    initial
    begin
        #2000000;
        bad_count++;
        finish_test;
    end
    initial
    begin
        repeat (3) @(negedge CORE_CLK);
        check({PLL_RESET, LOCKED, LOCK_FAIL}, 3'h4);
        check(PLL_FB_DIV, 11'h400);
        $display("reset test done");
        RESET = 1'b0;
        run = 1'b1;
        PLL_LOCK_IN = 1'b1;
        for (k = 0; k < 3; k++)
        begin
            {LOCAL_RATE_DIVIDE, MAIN_MODE, LOCAL_RATE_FACTOR} = rows[k][10:5];
            wait_for(0, 400);
            check(LOCKED, 1'b1);
            check(PLL_REF_SEL, rows[k][4]);
            check({RX_RECOVERY_EN, TX_TIMING_EN}, {2{rows[k][3]}});
            check(ATTEMPT_COUNT, 8'h0);
            cnt0 = 8'h0;
            repeat (80) @(negedge CORE_CLK) cnt0 += LOCAL_SYNC;
            check(cnt0, rows[k][2:0]);
            $display("lock row %0d done", k);
        end
        // Window expiry: lock indicator held low while frames keep coming
        MAIN_MODE = 1'b1;
        PLL_LOCK_IN = 1'b0;
        wait_for(2, 40);
        wait_for(1, WIN + 40);
        check({LOCK_FAIL, n >= WIN - 2 && n <= WIN + 2}, 2'h3);
        wait_for(2, 8);
        check(n >= 3 && n <= 5, 1'b1);
        @(negedge CORE_CLK);
        cnt0 = ATTEMPT_COUNT;
        wait_for(2, WIN + 40);
        @(negedge CORE_CLK);
        check(ATTEMPT_COUNT - cnt0, 8'h1);
        $display("window test done");
        // Tight frames reach the frame limit long before the window runs out
        fast = 1'b1;
        wait_for(1, WIN);
        check({LOCK_FAIL, FRAME_COUNT}, {1'b1, 9'h168});
        $display("frame limit test done");
        // Missing reference fails fast and never locks; lock indicator waits for a quiet sync
        fast = 1'b0;
        run = 1'b0;
        @(negedge CORE_CLK);
        PLL_LOCK_IN = 1'b1;
        wait_for(1, WIN);
        check({LOCK_FAIL, LOCKED, n <= MISS + 8}, 3'h5);
        // Corrupted preamble fails, then a clean one locks on retry
        run = 1'b1;
        MAIN_MODE = 1'b0;
        bad_req = 1'b1;
        wait_for(1, 100);
        check({LOCK_FAIL, LOCKED}, 2'h2);
        bad_req = 1'b0;
        wait_for(0, 400);
        check(LOCKED, 1'b1);
        $display("fault tests done");
        finish_test;
    end
endmodule
`default_nettype wire
